/* File: rtl/itr_pkg.sv */
// Package: register map, field layout, reset values and shared types of the bus target block
// Notes on behaviour
// - Target address lives in ID register bits 7:1, loaded from the strap after reset.
// - With second port enabled, its default address is strap address plus one.
// - Port view select makes port fields read and write the second port's copy.
// - ID bit 0 clear answers the strap address; set answers the programmed address.
// - Writing 1 to reset bit 1 resets all logic and registers, then self-clears; here the fairness pointer and status outputs are reset by srst only.
// - Writing 1 to reset bit 0 resets logic, keeps registers, then self-clears.
// - Logic-only reset reloads every strap-defaulted register with its strapped value.
// - Logic-only reset also restores offsets 0x18-0x1A and 0x48-0x55 to defaults.
// - Simultaneous local and remote register accesses are arbitrated without corruption.
// - A master losing arbitration releases the data line and retries when idle; here a losing request is held off with busy until granted.
package itr_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_TARGET_ID   = 8'h00;
    localparam logic [7:0] ADDR_RESET_CTRL  = 8'h01;
    localparam logic [7:0] ADDR_PORT_CTRL   = 8'h02;
    localparam logic [7:0] ADDR_MAILBOX_LO  = 8'h18;
    localparam logic [7:0] ADDR_MAILBOX_HI  = 8'h1a;
    localparam logic [7:0] ADDR_BANK_LO     = 8'h48;
    localparam logic [7:0] ADDR_BANK_HI     = 8'h55;

    // ==========================================================
    // Field positions
    localparam int BIT_ID_SELECT     = 0;
    localparam int BIT_LOGIC_RESET   = 0;
    localparam int BIT_FULL_RESET    = 1;
    localparam int BIT_PORT_VIEW_SEL = 0;
    localparam int BIT_PORT2_ENABLE  = 1;

    // ==========================================================
    // Reset values and timing
    localparam logic [7:0] RST_RESET_CTRL = 8'h00;
    localparam logic [7:0] RST_PORT_CTRL  = 8'h00;
    localparam logic [7:0] RST_GENERAL    = 8'h00;
    localparam int         RESET_PULSE_CYCLES = 4;

    // ==========================================================
    // Shared types
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } itr_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } itr_rsp_t;

    typedef enum logic [1:0] {
        ST_RUN       = 2'b00,
        ST_LOGIC_RST = 2'b01,
        ST_FULL_RST  = 2'b10
    } itr_state_t;

endpackage : itr_pkg

/* File: rtl/itr_reg_mem.sv */
// Memory: small general register array with registered read data and bulk default restore
module itr_reg_mem #(
    parameter int DEPTH = 256
) (
    input  wire logic       clock,
    input  wire logic       writeEn,
    input  wire logic [7:0] writeAddr,
    input  wire logic [7:0] writeData,
    input  wire logic [7:0] readAddr,
    input  wire logic       restoreAll,
    input  wire logic       restoreWindows,
    output      logic [7:0] readData
);
    import itr_pkg::*;

    initial begin
        if (DEPTH != 256) $error("itr_reg_mem: depth must be 256");
    end

    logic [7:0] mem [DEPTH];

    // ==========================================================
    // Storage; restore terms win over a write in the same cycle
    always_ff @(posedge clock) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (restoreAll) begin
                mem[i] <= RST_GENERAL;
            end else if (restoreWindows && ((i >= ADDR_MAILBOX_LO && i <= ADDR_MAILBOX_HI) ||
                                            (i >= ADDR_BANK_LO && i <= ADDR_BANK_HI))) begin
                mem[i] <= RST_GENERAL;
            end else if (writeEn && writeAddr == 8'(i)) begin
                mem[i] <= writeData;
            end
        end
    end

    // Registered read port
    always_ff @(posedge clock) begin
        readData <= mem[readAddr];
    end

endmodule : itr_reg_mem

/* File: rtl/itr_target_core.sv */
// Top: bus target address, digital reset controls and local/remote register arbitration
module itr_target_core #(
    parameter int PULSE_CYCLES = itr_pkg::RESET_PULSE_CYCLES
) (
    input  wire logic            clock,
    input  wire logic            srst,
    input  wire logic [6:0]      addressStrapInput,
    input  wire itr_pkg::itr_req_t localReq,
    input  wire itr_pkg::itr_req_t remoteReq,
    output      itr_pkg::itr_rsp_t localRsp,
    output      itr_pkg::itr_rsp_t remoteRsp,
    output      logic            localBusy,
    output      logic            remoteBusy,
    output      logic [6:0]      activeAddress,
    output      logic [6:0]      secondPortAddress,
    output      logic            secondPortBusEnable,
    output      logic            logicResetActive
);
    import itr_pkg::*;

    initial begin
        if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255) $error("itr_target_core: bad pulse length");
    end

    // Address seen by a port when it follows the strap or its own register
    function automatic logic [6:0] pickAddr(input logic useReg, input logic [6:0] regAddr,
                                            input logic [6:0] strapAddr);
        pickAddr = useReg ? regAddr : strapAddr;
    endfunction : pickAddr

    // Strap value captured on each cycle that a reset is active; no asynchronous load of a port value
    logic [6:0] strap_reg;
    logic [6:0] id0_reg;
    logic [6:0] id1_reg;
    logic       sel0_reg;
    logic       sel1_reg;
    logic [7:0] portCtrl_reg;
    itr_state_t state_reg;
    itr_state_t state_next;
    logic [7:0] pulseCnt_reg;
    logic       lastGrantRemote_reg;
    logic       fullRst;
    logic       logicRst;

    // ==========================================================
    // Reset sequencer: one-shot pulses after a write of 1 to a reset bit
    assign fullRst  = srst || state_reg == ST_FULL_RST;
    assign logicRst = state_reg == ST_LOGIC_RST;

    // Arbitration: one access is taken per cycle, the other waits
    itr_req_t grantReq;
    logic     grantRemote;
    logic     grantValid;
    always_comb begin
        grantRemote = 1'b0;
        if (localReq.valid && remoteReq.valid) begin
            grantRemote = !lastGrantRemote_reg;
        end else if (remoteReq.valid) begin
            grantRemote = 1'b1;
        end
        grantValid = (localReq.valid || remoteReq.valid) && state_reg == ST_RUN;
        grantReq   = grantRemote ? remoteReq : localReq;
    end

    logic wrEn;
    logic rdEn;
    assign wrEn = grantValid && grantReq.write;
    assign rdEn = grantValid && !grantReq.write;

    // Next state of the reset sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (wrEn && grantReq.addr == ADDR_RESET_CTRL) begin
                    if (grantReq.wdata[BIT_FULL_RESET]) begin
                        state_next = ST_FULL_RST;
                    end else if (grantReq.wdata[BIT_LOGIC_RESET]) begin
                        state_next = ST_LOGIC_RST;
                    end
                end
            end
            ST_LOGIC_RST, ST_FULL_RST: begin
                if (pulseCnt_reg == 8'(PULSE_CYCLES - 1)) begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_RUN;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Pulse length counter
    always_ff @(posedge clock) begin
        if (srst || state_reg == ST_RUN) begin
            pulseCnt_reg <= 8'h00;
        end else begin
            pulseCnt_reg <= pulseCnt_reg + 8'h01;
        end
    end

    // ==========================================================
    // Strap capture at every full or logic-only reset
    always_ff @(posedge clock) begin
        if (fullRst || logicRst) begin
            strap_reg <= addressStrapInput;
        end
    end

    // Identification register copies for both ports
    always_ff @(posedge clock) begin
        if (fullRst || logicRst) begin
            id0_reg <= addressStrapInput;
            id1_reg <= addressStrapInput + 7'h01;
        end else if (wrEn && grantReq.addr == ADDR_TARGET_ID) begin
            if (portCtrl_reg[BIT_PORT_VIEW_SEL]) begin
                id1_reg <= grantReq.wdata[7:1];
            end else begin
                id0_reg <= grantReq.wdata[7:1];
            end
        end
    end

    // Address source select per port
    always_ff @(posedge clock) begin
        if (fullRst) begin
            sel0_reg <= 1'b0;
            sel1_reg <= 1'b0;
        end else if (wrEn && grantReq.addr == ADDR_TARGET_ID) begin
            if (portCtrl_reg[BIT_PORT_VIEW_SEL]) begin
                sel1_reg <= grantReq.wdata[BIT_ID_SELECT];
            end else begin
                sel0_reg <= grantReq.wdata[BIT_ID_SELECT];
            end
        end
    end

    // Port control: view select and second port enable, kept over a logic-only reset
    always_ff @(posedge clock) begin
        if (fullRst) begin
            portCtrl_reg <= RST_PORT_CTRL;
        end else if (wrEn && grantReq.addr == ADDR_PORT_CTRL) begin
            portCtrl_reg <= {6'h00, grantReq.wdata[BIT_PORT2_ENABLE], grantReq.wdata[BIT_PORT_VIEW_SEL]};
        end
    end

    // Fairness pointer toggles when both sources contend
    always_ff @(posedge clock) begin
        if (srst) begin
            lastGrantRemote_reg <= 1'b0;
        end else if (grantValid) begin
            lastGrantRemote_reg <= grantRemote;
        end
    end

    // ==========================================================
    // General register storage
    logic [7:0] memData;
    itr_reg_mem #(
        .DEPTH(256)
    ) u_mem (
        .clock         (clock),
        .writeEn       (wrEn && grantReq.addr > ADDR_PORT_CTRL),
        .writeAddr     (grantReq.addr),
        .writeData     (grantReq.wdata),
        .readAddr      (grantReq.addr),
        .restoreAll    (fullRst),
        .restoreWindows(logicRst),
        .readData      (memData)
    );

    // Read return path: local registers one cycle behind the grant
    logic       rdPend_reg;
    logic       rdRemote_reg;
    logic       rdMem_reg;
    logic [7:0] rdLocal_reg;
    always_ff @(posedge clock) begin
        if (fullRst) begin
            rdPend_reg   <= 1'b0;
            rdRemote_reg <= 1'b0;
            rdMem_reg    <= 1'b0;
            rdLocal_reg  <= 8'h00;
        end else begin
            rdPend_reg   <= rdEn;
            rdRemote_reg <= grantRemote;
            rdMem_reg    <= grantReq.addr > ADDR_PORT_CTRL;
            if (grantReq.addr == ADDR_TARGET_ID) begin
                rdLocal_reg <= portCtrl_reg[BIT_PORT_VIEW_SEL] ? {id1_reg, sel1_reg} : {id0_reg, sel0_reg};
            end else if (grantReq.addr == ADDR_RESET_CTRL) begin
                rdLocal_reg <= RST_RESET_CTRL;
            end else if (grantReq.addr == ADDR_PORT_CTRL) begin
                rdLocal_reg <= portCtrl_reg;
            end else begin
                rdLocal_reg <= 8'h00;
            end
        end
    end

    // Answers: writes and reads alike answered two cycles after the grant
    logic wrAckLocal;
    logic wrAckRemote;
    always_ff @(posedge clock) begin
        if (fullRst) begin
            localRsp    <= '0;
            remoteRsp   <= '0;
            wrAckLocal  <= 1'b0;
            wrAckRemote <= 1'b0;
        end else begin
            wrAckLocal  <= wrEn && !grantRemote;
            wrAckRemote <= wrEn && grantRemote;
            localRsp.valid  <= wrAckLocal || (rdPend_reg && !rdRemote_reg);
            remoteRsp.valid <= wrAckRemote || (rdPend_reg && rdRemote_reg);
            localRsp.rdata  <= (rdPend_reg && !rdRemote_reg) ? (rdMem_reg ? memData : rdLocal_reg) : 8'h00;
            remoteRsp.rdata <= (rdPend_reg && rdRemote_reg) ? (rdMem_reg ? memData : rdLocal_reg) : 8'h00;
        end
    end

    // ==========================================================
    // Status outputs, all registered
    always_ff @(posedge clock) begin
        if (srst) begin
            localBusy           <= 1'b0;
            remoteBusy          <= 1'b0;
            activeAddress       <= 7'h00;
            secondPortAddress   <= 7'h00;
            secondPortBusEnable <= 1'b0;
            logicResetActive    <= 1'b0;
        end else begin
            // Loser of a contended cycle is held off until granted; uses the state that gated the grant,
            // so a request that starts a reset pulse is not reported busy although it was taken
            localBusy           <= localReq.valid && (grantRemote || state_reg != ST_RUN);
            remoteBusy          <= remoteReq.valid && (!grantRemote || state_reg != ST_RUN);
            activeAddress       <= pickAddr(sel0_reg, id0_reg, strap_reg);
            secondPortAddress   <= pickAddr(sel1_reg, id1_reg, strap_reg + 7'h01);
            secondPortBusEnable <= portCtrl_reg[BIT_PORT2_ENABLE];
            logicResetActive    <= state_next != ST_RUN;
        end
    end

endmodule : itr_target_core

/* File: testbench/itr_master_model.sv */
// Partner: behavioural bus master issuing single byte register accesses
module itr_master_model (
    input  wire logic              clock,
    input  wire logic              busy,
    output      itr_pkg::itr_req_t req,
    input  wire itr_pkg::itr_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ns;
    import itr_pkg::*;

    initial req = '0;

    // ====================
    // One access at a time, held until taken, then answer awaited; only plain register
    // accesses are issued, so no remote-slave traffic or bus condition can collide
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
        int   n;
        logic taken;
        ok = 1'b0;
        taken = 1'b0;
        q = 8'hxx;
        @(negedge clock);
        req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
        for (n = 0; n < 20 && !ok; n++) begin
            @(negedge clock);
            // Busy low after an edge with the request up means it was taken; drop it or it is taken again
            if (!taken && busy === 1'b0) begin
                taken = 1'b1;
                req <= '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
            end
            if (rsp.valid === 1'b1) begin
                ok = 1'b1;
                q = rsp.rdata;
            end
        end
        // Released fields show inverted junk so stale values cannot pass
        if (!taken) begin
            req <= '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
        end
    endtask : xfer
endmodule : itr_master_model

/* File: testbench/itr_target_assertions.sv */
// Checker: port-level assertions bound onto the bus target core
module itr_target_assertions #(
    parameter int PULSE_CYCLES = 4
) (
    input wire logic              clock,
    input wire logic              srst,
    input wire logic [6:0]        addressStrapInput,
    input wire itr_pkg::itr_req_t localReq,
    input wire itr_pkg::itr_req_t remoteReq,
    input wire itr_pkg::itr_rsp_t localRsp,
    input wire itr_pkg::itr_rsp_t remoteRsp,
    input wire logic              localBusy,
    input wire logic              remoteBusy,
    input wire logic [6:0]        activeAddress,
    input wire logic [6:0]        secondPortAddress,
    input wire logic              secondPortBusEnable,
    input wire logic              logicResetActive
);
    timeunit 1ns;
    timeprecision 1ns;
    import itr_pkg::*;
    logic [7:0] pulseLen_reg;

    // ====================
    // Length of each self-clearing pulse; counter avoids a long repetition
    always_ff @(posedge clock) begin
        if (srst) begin
            pulseLen_reg <= 8'h00;
        end else begin
            pulseLen_reg <= logicResetActive ? pulseLen_reg + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    // ====================
    // Assertions
    strap_addr_a: assert property ($fell(srst) |-> ##[1:2] activeAddress == addressStrapInput)
        else $error("answered address differs from strap after reset");
    quiet_release_a: assert property ($fell(srst) |-> !localRsp.valid && !remoteRsp.valid)
        else $error("response seen right after reset");
    pulse_len_a: assert property ($fell(logicResetActive) |-> pulseLen_reg == 8'(PULSE_CYCLES))
        else $error("self-clearing pulse has wrong length");
    local_cause_a: assert property (localRsp.valid |-> $past(localReq.valid, 2))
        else $error("local response without a request");
    remote_cause_a: assert property (remoteRsp.valid |-> $past(remoteReq.valid, 2))
        else $error("remote response without a request");
    local_wait_a: assert property (localBusy |-> $past(localReq.valid))
        else $error("local busy without a request");
    remote_wait_a: assert property (remoteBusy |-> $past(remoteReq.valid))
        else $error("remote busy without a request");
    single_grant_a: assert property (!(localRsp.valid && remoteRsp.valid))
        else $error("both masters answered in one cycle");

    cover property (localBusy || remoteBusy);
    cover property ($fell(logicResetActive));
    cover property (remoteRsp.valid);
endmodule : itr_target_assertions

bind itr_target_core itr_target_assertions #(.PULSE_CYCLES(PULSE_CYCLES)) i_itr_target_assertions (
    .clock(clock), .srst(srst), .addressStrapInput(addressStrapInput), .localReq(localReq),
    .remoteReq(remoteReq), .localRsp(localRsp), .remoteRsp(remoteRsp), .localBusy(localBusy),
    .remoteBusy(remoteBusy), .activeAddress(activeAddress), .secondPortAddress(secondPortAddress),
    .secondPortBusEnable(secondPortBusEnable), .logicResetActive(logicResetActive));

/* File: testbench/tb.sv */
// Testbench: two bus masters exercise the target core
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import itr_pkg::*;
    localparam int PULSE = 4;
    logic       clock = 1'b0;
    logic       srst = 1'b1;
    logic [6:0] strap = 7'h0c;
    itr_req_t   lReq;
    itr_req_t   rReq;
    itr_rsp_t   lRsp;
    itr_rsp_t   rRsp;
    logic       lBusy;
    logic       rBusy;
    logic       p2En;
    logic       rstAct;
    logic [6:0] actAddr;
    logic [6:0] p2Addr;
    logic [7:0] qL;
    logic [7:0] qR;
    logic       ok;
    logic       pulseSeen = 1'b0;
    logic       busySeen = 1'b0;
    int         num_errors = 0;
    int         checks_done = 0;

    always #50 clock = ~clock;
    // Sticky flags so one-cycle events are not missed between checks
    always @(posedge clock) begin
        if (rstAct === 1'b1) pulseSeen <= 1'b1;
        if ((lBusy | rBusy) === 1'b1) busySeen <= 1'b1;
    end

    itr_target_core #(.PULSE_CYCLES(PULSE)) i_itr_target_core (
        .clock(clock), .srst(srst), .addressStrapInput(strap), .localReq(lReq), .remoteReq(rReq),
        .localRsp(lRsp), .remoteRsp(rRsp), .localBusy(lBusy), .remoteBusy(rBusy), .activeAddress(actAddr),
        .secondPortAddress(p2Addr), .secondPortBusEnable(p2En), .logicResetActive(rstAct));
    itr_master_model i_itr_master_model (.clock(clock), .busy(lBusy), .req(lReq), .rsp(lRsp));
    itr_master_model i_itr_master_model_r (.clock(clock), .busy(rBusy), .req(rReq), .rsp(rRsp));

    // ====================
    // Shared helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_itr_master_model.xfer(1'b1, a, d, qL, ok);
        check({7'h00, ok}, 8'h01);
    endtask : wr
    task automatic rdck(input logic [7:0] a, input logic [7:0] exp);
        i_itr_master_model.xfer(1'b0, a, 8'h00, qL, ok);
        check({7'h00, ok}, 8'h01);
        check(qL, exp);
    endtask : rdck
    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask : settle

    // ====================
    // Scenarios
    task automatic t_reset;
        check({1'b0, actAddr}, {1'b0, strap});
        rdck(ADDR_TARGET_ID, {strap, 1'b0});
        rdck(ADDR_RESET_CTRL, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_select;
        wr(ADDR_TARGET_ID, 8'h67);
        settle(3);
        check({1'b0, actAddr}, 8'h33);
        rdck(ADDR_TARGET_ID, 8'h67);
        wr(ADDR_TARGET_ID, 8'h66);
        settle(3);
        check({1'b0, actAddr}, {1'b0, strap});
        $display("test select done");
    endtask : t_select
    task automatic t_port2;
        wr(ADDR_PORT_CTRL, 8'h02);
        settle(3);
        check({7'h00, p2En}, 8'h01);
        check({1'b0, p2Addr}, {1'b0, strap + 7'h01});
        wr(ADDR_PORT_CTRL, 8'h03);
        wr(ADDR_TARGET_ID, 8'h88);
        rdck(ADDR_TARGET_ID, 8'h88);
        check({1'b0, actAddr}, {1'b0, strap});
        wr(ADDR_PORT_CTRL, 8'h00);
        rdck(ADDR_TARGET_ID, 8'h66);
        $display("test second port done");
    endtask : t_port2
    task automatic t_logic;
        wr(ADDR_TARGET_ID, 8'h67);
        wr(ADDR_MAILBOX_LO, 8'h5a);
        wr(ADDR_MAILBOX_HI, 8'h5b);
        wr(ADDR_BANK_HI, 8'ha5);
        wr(8'h20, 8'h3c);
        strap = 7'h1a;
        pulseSeen = 1'b0;
        wr(ADDR_RESET_CTRL, 8'h01);
        settle(PULSE + 4);
        check({7'h00, pulseSeen}, 8'h01);
        rdck(ADDR_MAILBOX_LO, 8'h00);
        rdck(ADDR_MAILBOX_HI, 8'h00);
        rdck(ADDR_BANK_HI, 8'h00);
        rdck(8'h20, 8'h3c);
        rdck(ADDR_RESET_CTRL, 8'h00);
        rdck(ADDR_TARGET_ID, 8'h35);
        check({1'b0, actAddr}, 8'h1a);
        $display("test logic reset done");
    endtask : t_logic
    task automatic t_full;
        wr(ADDR_RESET_CTRL, 8'h00);
        settle(2);
        check({7'h00, rstAct}, 8'h00);
        wr(ADDR_PORT_CTRL, 8'h02);
        pulseSeen = 1'b0;
        // A full reset clears the answer in flight, so this write is never acknowledged
        i_itr_master_model.xfer(1'b1, ADDR_RESET_CTRL, 8'h02, qL, ok);
        check({7'h00, ok}, 8'h00);
        settle(PULSE + 4);
        check({7'h00, pulseSeen}, 8'h01);
        check({7'h00, p2En}, 8'h00);
        rdck(8'h20, 8'h00);
        rdck(ADDR_TARGET_ID, {strap, 1'b0});
        rdck(ADDR_RESET_CTRL, 8'h00);
        $display("test full reset done");
    endtask : t_full
    task automatic t_contend;
        busySeen = 1'b0;
        fork
            i_itr_master_model.xfer(1'b1, ADDR_BANK_LO, 8'h11, qL, ok);
            i_itr_master_model_r.xfer(1'b1, 8'h49, 8'h22, qR, ok);
        join
        fork
            i_itr_master_model.xfer(1'b0, 8'h49, 8'h00, qL, ok);
            i_itr_master_model_r.xfer(1'b0, ADDR_BANK_LO, 8'h00, qR, ok);
        join
        check(qL, 8'h22);
        check(qR, 8'h11);
        check({7'h00, busySeen}, 8'h01);
        $display("test contention done");
    endtask : t_contend

    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (12) @(negedge clock);
        srst = 1'b0;
        settle(3);
        t_reset();
        t_select();
        t_port2();
        t_logic();
        t_full();
        t_contend();
        tally_and_finish();
    end
    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clock);
        num_errors++;
        tally_and_finish();
    end
endmodule : tb
